/* hdl/vsc_consts.vh */
// Constants for the virtual scan-chain user logic: register offsets,
// field positions, reset values and decode codes.
// Assumes inclusion by bare name from the design and verification files.
`ifndef VSC_CONSTS_VH
`define VSC_CONSTS_VH

// ****************************************************************
// Register offsets (byte addresses, one aligned word each)
// ****************************************************************
`define VSC_OFF_CTRL 8'h00
`define VSC_OFF_STATUS 8'h04
`define VSC_OFF_SHIFT 8'h08
`define VSC_OFF_COUNT 8'h0c
`define VSC_OFF_CAPTURE 8'h10
`define VSC_OFF_EVENTS 8'h14

// ****************************************************************
// Control register fields and reset value
// ****************************************************************
`define VSC_CTRL_CODE_SEL 0
`define VSC_CTRL_IRCAP_LO 2
`define VSC_CTRL_IRCAP_HI 3
`define VSC_CTRL_RESET 4'h0

// ****************************************************************
// Status register fields
// ****************************************************************
`define VSC_ST_IR_LO 0
`define VSC_ST_IR_HI 1
`define VSC_ST_STB_LO 2
`define VSC_ST_STB_HI 9
`define VSC_ST_SEL 10
`define VSC_ST_BYPASS 11
`define VSC_ST_TDO 12
`define VSC_ST_TMS 13

// ****************************************************************
// Chain-select codes of the two-bit virtual instruction
// ****************************************************************
`define VSC_CODE_LOAD_A 2'h1
`define VSC_CODE_LOAD_B 2'h2

// ****************************************************************
// Synchroniser bus layout
// ****************************************************************
`define VSC_SYNC_W 13
`define VSC_SB_TCK 0
`define VSC_SB_TDI 1
`define VSC_SB_TMS 2
`define VSC_SB_IR_LO 3
`define VSC_SB_IR_HI 4
`define VSC_SB_CDR 5
`define VSC_SB_E1DR 6
`define VSC_SB_E2DR 7
`define VSC_SB_PDR 8
`define VSC_SB_SDR 9
`define VSC_SB_UDR 10
`define VSC_SB_UIR 11
`define VSC_SB_CIR 12

`endif

/* hdl/vsc_sync3.v */
// Three-stage input synchroniser, one generate lane per bit.
// Assumes inputs are asynchronous to clk; output moves only when
// the second and third stages agree.
`timescale 1ns/10ps

module vsc_sync3 #(
    parameter W = 1
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] din,
    output wire [W-1:0] dout
);

    // ****************************************************************
    // Per-bit lanes
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_lane
            reg s1_ff;
            reg s2_ff;
            reg s3_ff;
            reg q_ff;
            // First stage feeds only the second
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                    s3_ff <= 1'b0;
                    q_ff <= 1'b0;
                end else begin
                    s1_ff <= din[i];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    if (s2_ff == s3_ff) begin
                        q_ff <= s3_ff;
                    end
                end
            end
            assign dout[i] = q_ff;
        end
    endgenerate

endmodule

/* hdl/vsc_user.v */
// Virtual scan-chain user logic: chain decode, 4-bit data shift
// register, bypass bit, serial-output select and a free counter,
// with an AHB-Lite register slave for software.
// Assumes scan-side signals arrive asynchronously from the virtual
// instance and the scan clock is far slower than hclk (8x or more).
//
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps

`include "vsc_consts.vh"

module vsc_user (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire scan_tck,
    input wire scan_tdi,
    input wire mode_sel_in,
    input wire [1:0] virtual_instr_value,
    input wire capture_data_strobe,
    input wire exit_one_data_strobe,
    input wire exit_two_data_strobe,
    input wire pause_data_strobe,
    input wire shift_data_strobe,
    input wire update_data_strobe,
    input wire update_instr_strobe,
    input wire capture_instr_strobe,
    output wire scan_tdo,
    output wire mode_sel_out,
    output wire [1:0] virtual_instr_capture,
    output wire chain_selected,
    output wire [3:0] free_counter
);

    // ****************************************************************
    // Synchronised scan-side inputs
    // ****************************************************************
    wire [`VSC_SYNC_W-1:0] raw_bus;
    wire [`VSC_SYNC_W-1:0] sync_bus;

    assign raw_bus = {capture_instr_strobe, update_instr_strobe,
                      update_data_strobe, shift_data_strobe,
                      pause_data_strobe, exit_two_data_strobe,
                      exit_one_data_strobe, capture_data_strobe,
                      virtual_instr_value, mode_sel_in, scan_tdi, scan_tck};

    // Scan side is another clock's domain
    vsc_sync3 #(
        .W(`VSC_SYNC_W)
    ) u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .din(raw_bus),
        .dout(sync_bus)
    );

    wire tck_s;
    wire tdi_s;
    wire tms_s;
    wire [1:0] ir_s;
    wire cdr_s;
    wire e1dr_s;
    wire e2dr_s;
    wire pdr_s;
    wire sdr_s;
    wire udr_s;
    wire uir_s;
    wire cir_s;

    assign tck_s = sync_bus[`VSC_SB_TCK];
    assign tdi_s = sync_bus[`VSC_SB_TDI];
    assign tms_s = sync_bus[`VSC_SB_TMS];
    assign ir_s = sync_bus[`VSC_SB_IR_HI:`VSC_SB_IR_LO];
    assign cdr_s = sync_bus[`VSC_SB_CDR];
    assign e1dr_s = sync_bus[`VSC_SB_E1DR];
    assign e2dr_s = sync_bus[`VSC_SB_E2DR];
    assign pdr_s = sync_bus[`VSC_SB_PDR];
    assign sdr_s = sync_bus[`VSC_SB_SDR];
    assign udr_s = sync_bus[`VSC_SB_UDR];
    assign uir_s = sync_bus[`VSC_SB_UIR];
    assign cir_s = sync_bus[`VSC_SB_CIR];

    // ****************************************************************
    // Scan-clock edge detection
    // ****************************************************************
    reg tck_prev_ff;
    wire tck_rise;
    wire tck_fall;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tck_prev_ff <= 1'b0;
        end else begin
            tck_prev_ff <= tck_s;
        end
    end

    assign tck_rise = tck_s & ~tck_prev_ff;
    assign tck_fall = ~tck_s & tck_prev_ff;

    // ****************************************************************
    // Control register and chain decode
    // ****************************************************************
    reg [3:0] ctrl_ff;
    reg [3:0] nxt_ctrl;
    wire [1:0] load_code;
    wire sel;

    // Code bit lets software settle which load code the host uses
    assign load_code = ctrl_ff[`VSC_CTRL_CODE_SEL] ? `VSC_CODE_LOAD_B : `VSC_CODE_LOAD_A;
    // Value follows the last instruction scan
    assign sel = (ir_s == load_code);

    // ****************************************************************
    // Data shift register and bypass bit
    // ****************************************************************
    reg [3:0] shift_ff;
    reg [3:0] nxt_shift;
    reg bypass_ff;
    reg nxt_bypass;

    always @* begin
        nxt_shift = shift_ff;
        nxt_bypass = bypass_ff;
        if (tck_rise) begin
            nxt_bypass = tdi_s;
            // Shift register takes serial input only while the chain is selected and shifting; the bypass bit takes it on every rise
            if (sel && sdr_s) begin
                nxt_shift = {tdi_s, shift_ff[3:1]};
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_ff <= 4'h0;
            bypass_ff <= 1'b0;
        end else begin
            shift_ff <= nxt_shift;
            bypass_ff <= nxt_bypass;
        end
    end

    // ****************************************************************
    // Serial output and mode-select mirror
    // ****************************************************************
    reg tdo_ff;
    reg nxt_tdo;
    reg tms_out_ff;
    reg sel_ff;

    // Changed on scan-clock fall so it is settled for the next rise
    always @* begin
        nxt_tdo = tdo_ff;
        if (tck_fall) begin
            nxt_tdo = sel ? shift_ff[0] : bypass_ff;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tdo_ff <= 1'b0;
            tms_out_ff <= 1'b0;
            sel_ff <= 1'b0;
        end else begin
            tdo_ff <= nxt_tdo;
            tms_out_ff <= tms_s;
            sel_ff <= sel;
        end
    end

    // ****************************************************************
    // Free counter on the system clock
    // ****************************************************************
    reg [3:0] count_ff;
    reg [3:0] nxt_count;
    reg [3:0] capture_ff;
    reg [3:0] nxt_capture;
    wire load_cond;

    // Exit-one only comes after shifting stops, so shift_ff is stable
    assign load_cond = sel && e1dr_s;

    always @* begin
        nxt_count = count_ff + 4'h1;
        nxt_capture = capture_ff;
        if (load_cond) begin
            nxt_count = shift_ff;
            nxt_capture = shift_ff;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_ff <= 4'h0;
            capture_ff <= 4'h0;
        end else begin
            count_ff <= nxt_count;
            capture_ff <= nxt_capture;
        end
    end

    // ****************************************************************
    // Update-event counters
    // ****************************************************************
    reg udr_prev_ff;
    reg uir_prev_ff;
    reg [7:0] udr_cnt_ff;
    reg [7:0] uir_cnt_ff;
    reg [7:0] nxt_udr_cnt;
    reg [7:0] nxt_uir_cnt;
    reg ev_clr;

    // Strobes offered to software
    always @* begin
        nxt_udr_cnt = udr_cnt_ff;
        nxt_uir_cnt = uir_cnt_ff;
        if (ev_clr) begin
            nxt_udr_cnt = 8'h00;
            nxt_uir_cnt = 8'h00;
        end
        // An event in the same cycle as a clear counts from zero, leaving a count of one
        if (udr_s && !udr_prev_ff) begin
            nxt_udr_cnt = ev_clr ? 8'h01 : udr_cnt_ff + 8'h01;
        end
        if (uir_s && !uir_prev_ff) begin
            nxt_uir_cnt = ev_clr ? 8'h01 : uir_cnt_ff + 8'h01;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            udr_prev_ff <= 1'b0;
            uir_prev_ff <= 1'b0;
            udr_cnt_ff <= 8'h00;
            uir_cnt_ff <= 8'h00;
        end else begin
            udr_prev_ff <= udr_s;
            uir_prev_ff <= uir_s;
            udr_cnt_ff <= nxt_udr_cnt;
            uir_cnt_ff <= nxt_uir_cnt;
        end
    end

    // ****************************************************************
    // AHB-Lite slave, zero wait states
    // ****************************************************************
    reg wr_pend_ff;
    reg [7:0] wr_addr_ff;
    reg [31:0] rdata_ff;
    reg [31:0] nxt_rdata;
    wire addr_phase;
    wire [7:0] aoff;
    wire [31:0] status_word;

    assign addr_phase = hsel && htrans[1] && hready;
    assign aoff = {haddr[7:2], 2'b00};

    assign status_word = {18'h0_0000, tms_s, tdo_ff, bypass_ff, sel,
                          cir_s, uir_s, udr_s, sdr_s, pdr_s, e2dr_s, e1dr_s, cdr_s,
                          ir_s};

    // Read data is latched in the address phase
    always @* begin
        nxt_rdata = rdata_ff;
        if (addr_phase && !hwrite) begin
            case (aoff)
                `VSC_OFF_CTRL: begin
                    nxt_rdata = {28'h000_0000, ctrl_ff};
                end
                `VSC_OFF_STATUS: begin
                    nxt_rdata = status_word;
                end
                `VSC_OFF_SHIFT: begin
                    nxt_rdata = {28'h000_0000, shift_ff};
                end
                `VSC_OFF_COUNT: begin
                    nxt_rdata = {28'h000_0000, count_ff};
                end
                `VSC_OFF_CAPTURE: begin
                    nxt_rdata = {28'h000_0000, capture_ff};
                end
                `VSC_OFF_EVENTS: begin
                    nxt_rdata = {16'h0000, uir_cnt_ff, udr_cnt_ff};
                end
                default: begin
                    nxt_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // Write data arrives in the data phase
    always @* begin
        nxt_ctrl = ctrl_ff;
        ev_clr = 1'b0;
        if (wr_pend_ff) begin
            if (wr_addr_ff == `VSC_OFF_CTRL) begin
                nxt_ctrl = hwdata[3:0];
            end
            if (wr_addr_ff == `VSC_OFF_EVENTS) begin
                ev_clr = 1'b1;
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rdata_ff <= 32'h0000_0000;
            ctrl_ff <= `VSC_CTRL_RESET;
        end else begin
            wr_pend_ff <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_ff <= aoff;
            end
            rdata_ff <= nxt_rdata;
            ctrl_ff <= nxt_ctrl;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    reg hreadyout_ff;
    reg hresp_ff;

    // Ready from the first clock after reset (low during reset), always OKAY; no wait state is ever needed
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff <= 1'b0;
            hresp_ff <= 1'b0;
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end
    end

    assign hrdata = rdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign scan_tdo = tdo_ff;
    assign mode_sel_out = tms_out_ff;
    assign virtual_instr_capture = ctrl_ff[`VSC_CTRL_IRCAP_HI:`VSC_CTRL_IRCAP_LO];
    assign chain_selected = sel_ff;
    assign free_counter = count_ff;

endmodule

/* dv/vsc_user_sva.sv */
// Port checker for the virtual scan-chain user logic, bound into vsc_user.
// Assumes CTRL code select stays 0 and scan inputs change only while
// the scan clock is low.
`timescale 1ns/10ps

`include "vsc_consts.vh"

module vsc_user_sva (
    input wire hclk,
    input wire hresetn,
    input wire scan_tck,
    input wire scan_tdi,
    input wire mode_sel_in,
    input wire [1:0] virtual_instr_value,
    input wire exit_one_data_strobe,
    input wire scan_tdo,
    input wire mode_sel_out,
    input wire chain_selected,
    input wire [3:0] free_counter
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_fall_bypass;
        $fell(scan_tck) && !chain_selected;
    endsequence
    // Reset kept out of the window: the counter's first step comes from the reset value
    sequence s_e1_quiet;
        (hresetn && !exit_one_data_strobe)[*8];
    endsequence
    sequence s_load_held;
        (exit_one_data_strobe && chain_selected)[*8];
    endsequence
    property p_tdo_stable;
        $rose(scan_tck) |-> ##5 $stable(scan_tdo)[*3];
    endproperty
    property p_mode_mirror;
        (hresetn && $stable(mode_sel_in))[*7] |-> mode_sel_out == mode_sel_in;
    endproperty
    property p_decode;
        $stable(virtual_instr_value)[*8]
            |-> chain_selected == (virtual_instr_value == `VSC_CODE_LOAD_A);
    endproperty
    // Bypass bit seen one fall later, so tdi is taken from before the fall
    property p_tdo_bypass;
        s_fall_bypass |-> ##7 (chain_selected || scan_tdo == $past(scan_tdi, 8));
    endproperty
    property p_cnt_inc;
        s_e1_quiet |-> free_counter == $past(free_counter) + 4'h1;
    endproperty
    property p_cnt_first;
        $rose(hresetn) |=> free_counter == 4'h1;
    endproperty
    property p_cnt_hold;
        s_load_held |-> $stable(free_counter);
    endproperty
    property p_cnt_sel_off;
        (hresetn && !chain_selected)[*8] |-> free_counter == $past(free_counter) + 4'h1;
    endproperty
    a_tdo_stable: assert property (p_tdo_stable)
        else $error("serial output moved while scan clock high");
    a_mode_mirror: assert property (p_mode_mirror)
        else $error("mode-select copy differs");
    a_decode: assert property (p_decode)
        else $error("chain select decode wrong");
    a_tdo_bypass: assert property (p_tdo_bypass)
        else $error("bypass output wrong");
    a_cnt_inc: assert property (p_cnt_inc)
        else $error("counter did not increment");
    a_cnt_first: assert property (p_cnt_first)
        else $error("counter wrong after reset");
    a_cnt_hold: assert property (p_cnt_hold)
        else $error("counter not held during load");
    a_cnt_sel_off: assert property (p_cnt_sel_off)
        else $error("counter loaded while chain not selected");
endmodule

bind vsc_user vsc_user_sva vsc_user_sva_inst (
    .hclk(hclk), .hresetn(hresetn), .scan_tck(scan_tck), .scan_tdi(scan_tdi),
    .mode_sel_in(mode_sel_in), .virtual_instr_value(virtual_instr_value),
    .exit_one_data_strobe(exit_one_data_strobe), .scan_tdo(scan_tdo),
    .mode_sel_out(mode_sel_out), .chain_selected(chain_selected),
    .free_counter(free_counter)
);

/* dv/vsc_scan_model.sv */
// Behavioural model of the virtual scan instance feeding the user logic.
// Assumes hclk runs 8x its scan clock; the bench calls its scan tasks.
`timescale 1ns/10ps

module vsc_scan_model (
    input wire hclk,
    output logic tck,
    output logic tdi,
    output logic tms,
    output logic [1:0] ir,
    output logic cdr,
    output logic e1dr,
    output logic e2dr,
    output logic pdr,
    output logic sdr,
    output logic udr,
    output logic uir,
    output logic cir
);
    initial begin
        {tck, tdi, cdr, e1dr, e2dr, pdr, sdr, udr, uir, cir} = '0;
        tms = 1'b1;
        ir = 2'h0;
    end
    // ****************************************
    // Scan periods
    // ****************************************
    // Clock stands still between frames
    task automatic tick;
        repeat (4) @(posedge hclk);
        tck <= 1'b1;
        repeat (4) @(posedge hclk);
        tck <= 1'b0;
    endtask
    // Data line released: toggled so stale data never looks valid
    task automatic idle_tick;
        tdi <= ~tdi;
        tick;
    endtask
    task automatic ir_scan(input logic [1:0] code);
        tms <= 1'b0;
        cir <= 1'b1;
        idle_tick;
        cir <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            tdi <= code[i];
            tick;
        end
        uir <= 1'b1;
        ir <= code;
        idle_tick;
        uir <= 1'b0;
        tms <= 1'b1;
    endtask
    task automatic dr_scan(input logic [7:0] bits, input int n, input logic paused);
        tms <= 1'b0;
        cdr <= 1'b1;
        idle_tick;
        cdr <= 1'b0;
        sdr <= 1'b1;
        for (int i = 0; i < n; i++) begin
            tdi <= bits[i];
            tick;
        end
        sdr <= 1'b0;
        e1dr <= 1'b1;
        idle_tick;
        e1dr <= 1'b0;
        if (paused) begin
            pdr <= 1'b1;
            idle_tick;
            pdr <= 1'b0;
            e2dr <= 1'b1;
            idle_tick;
            e2dr <= 1'b0;
        end
        udr <= 1'b1;
        idle_tick;
        udr <= 1'b0;
        tms <= 1'b1;
    endtask
endmodule

/* dv/vsc_user_tb.sv */
// Self-checking bench for vsc_user with AHB-Lite register access.
// Assumes vsc_scan_model drives the scan side; CTRL code select stays 0.
`timescale 1ns/10ps

`include "vsc_consts.vh"

module vsc_user_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] rd;
    logic [3:0] exp_sh;
    wire [31:0] hrdata;
    wire hreadyout, hresp, scan_tdo, mode_sel_out, chain_selected;
    wire scan_tck, scan_tdi, mode_sel_in, cdr, e1dr, e2dr, pdr, sdr, udr, uir, cir;
    wire [1:0] ir, virtual_instr_capture;
    wire [3:0] free_counter;
    int errors = 0;
    int tests_run = 0;
    int n_udr = 0;
    int n_uir = 0;

    always #50 hclk = ~hclk;

    vsc_scan_model vsc_scan_model_inst (.hclk(hclk), .tck(scan_tck), .tdi(scan_tdi),
        .tms(mode_sel_in), .ir(ir), .cdr(cdr), .e1dr(e1dr), .e2dr(e2dr), .pdr(pdr),
        .sdr(sdr), .udr(udr), .uir(uir), .cir(cir));
    vsc_user vsc_user_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .scan_tck(scan_tck),
        .scan_tdi(scan_tdi), .mode_sel_in(mode_sel_in), .virtual_instr_value(ir),
        .capture_data_strobe(cdr), .exit_one_data_strobe(e1dr),
        .exit_two_data_strobe(e2dr), .pause_data_strobe(pdr),
        .shift_data_strobe(sdr), .update_data_strobe(udr),
        .update_instr_strobe(uir), .capture_instr_strobe(cir),
        .scan_tdo(scan_tdo), .mode_sel_out(mode_sel_out),
        .virtual_instr_capture(virtual_instr_capture),
        .chain_selected(chain_selected), .free_counter(free_counter));

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [31:0] a, input logic [31:0] exp, input string what);
        ahb(a, 1'b0, 32'h0000_0000);
        chk(rd, exp, what);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs;
        chk_reg(`VSC_OFF_CTRL, 32'h0000_0000, "ctrl reset");
        chk_reg(32'h0000_0040, 32'h0000_0000, "unmapped read");
        ahb(`VSC_OFF_CTRL, 1'b1, 32'h0000_000c);
        ahb(32'h0000_0040, 1'b1, 32'hffff_ffff);
        chk(hresp, 1'b0, "okay response");
        chk_reg(`VSC_OFF_CTRL, 32'h0000_000c, "ctrl write");
        chk(virtual_instr_capture, 2'h3, "instr capture");
        $display("test regs done");
    endtask
    // Six bits push the oldest out, three bits leave a partial mix
    task automatic t_load;
        logic [7:0] bits[3] = '{8'h0b, 8'h35, 8'h02};
        int len[3] = '{4, 6, 3};
        vsc_scan_model_inst.ir_scan(2'h1);
        n_uir++;
        repeat (8) @(posedge hclk);
        chk(chain_selected, 1'b1, "select");
        ahb(`VSC_OFF_STATUS, 1'b0, 32'h0000_0000);
        chk(rd & 32'h0000_2403, 32'h0000_2401, "status");
        exp_sh = 4'h0;
        for (int k = 0; k < 3; k++) begin
            vsc_scan_model_inst.dr_scan(bits[k], len[k], k == 2);
            n_udr++;
            for (int i = 0; i < len[k]; i++) exp_sh = {bits[k][i], exp_sh[3:1]};
            repeat (8) @(posedge hclk);
            chk(scan_tdo, exp_sh[0], "tdo shift bit");
            chk_reg(`VSC_OFF_SHIFT, exp_sh, "shift");
            chk_reg(`VSC_OFF_CAPTURE, exp_sh, "counter load");
        end
        $display("test load done");
    endtask
    task automatic t_decode;
        for (int c = 0; c < 4; c++) begin
            vsc_scan_model_inst.ir_scan(c[1:0]);
            n_uir++;
            repeat (8) @(posedge hclk);
            chk(chain_selected, c == 1, "decode");
        end
        vsc_scan_model_inst.dr_scan(8'h0f, 4, 1'b0);
        n_udr++;
        repeat (8) @(posedge hclk);
        chk(scan_tdo, scan_tdi, "bypass out");
        chk_reg(`VSC_OFF_SHIFT, exp_sh, "shift kept");
        chk_reg(`VSC_OFF_CAPTURE, exp_sh, "no load");
        // Read value is one step behind the port seen at the data-phase edge
        ahb(`VSC_OFF_COUNT, 1'b0, 32'h0000_0000);
        chk(free_counter, 4'(rd[3:0] + 4'h1), "counter step");
        $display("test decode done");
    endtask
    task automatic t_events;
        chk_reg(`VSC_OFF_EVENTS, {16'h0000, n_uir[7:0], n_udr[7:0]}, "events");
        ahb(`VSC_OFF_EVENTS, 1'b1, 32'h0000_0000);
        chk_reg(`VSC_OFF_EVENTS, 32'h0000_0000, "events clear");
        $display("test events done");
    endtask

    initial begin
        #2_000_000;
        errors++;
        end_of_test;
    end
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (8) @(posedge hclk);
        t_regs;
        t_load;
        t_decode;
        t_events;
        end_of_test;
    end
endmodule
